/* bcpc_pkg.sv */
// Constants, field layouts and state types for the battery charge port control block.
// Assumes one 100 MHz clock and an asynchronous active-high chip reset.
package bcpc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ          = 100_000_000;
  localparam int MS_PER_S        = 1000;
  localparam int US_PER_S        = 1_000_000;
  localparam int TICK_CYC        = CLK_HZ / MS_PER_S;
  localparam int SETTLE_US       = 40;
  localparam int SETTLE_CYC      = (SETTLE_US * (CLK_HZ / US_PER_S) < 1) ? 1 :
                                   SETTLE_US * (CLK_HZ / US_PER_S);
  localparam int RETRY_SHORT_S   = 1;
  localparam int RETRY_LONG_S    = 10;
  localparam logic [13:0] RETRY_SHORT_MS = 14'(RETRY_SHORT_S * MS_PER_S);
  localparam logic [13:0] RETRY_LONG_MS  = 14'(RETRY_LONG_S * MS_PER_S);
  localparam logic [1:0]  RETRY_SHORT_MAX = 2'h3;

  // ****************************************************************
  // Charger type codes
  // ****************************************************************
  localparam logic [2:0] CT_NONE = 3'h0;
  localparam logic [2:0] CT_DCP  = 3'h1;
  localparam logic [2:0] CT_CDP  = 3'h2;
  localparam logic [2:0] CT_SDP  = 3'h3;
  localparam logic [2:0] CT_PLO  = 3'h4;
  localparam logic [2:0] CT_PHI  = 3'h5;
  localparam logic [2:0] CT_PSH  = 3'h6;

  localparam logic [1:0] PROP_NONE = 2'h0;
  localparam logic [1:0] PROP_LO   = 2'h1;
  localparam logic [1:0] PROP_HI   = 2'h2;
  localparam logic [1:0] PROP_SH   = 2'h3;

  // ****************************************************************
  // Port charge enable register
  // ****************************************************************
  localparam int         PORTS        = 4;
  localparam int         PCE_W        = 8;
  localparam int         PCE_PORT1    = 1;
  localparam logic [7:0] PCE_RST      = 8'h00;
  localparam logic [7:0] PCE_RSVD_MSK = 8'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       shorted;
    logic       pulldowns;
    logic       reflect;
    logic [1:0] prop;
  } bcpc_sense_t;

  typedef enum logic [1:0] {DS_IDLE, DS_SETTLE, DS_DONE} bcpc_det_st_t;
  typedef enum logic [1:0] {PS_OFF, PS_ON, PS_BACKOFF} bcpc_port_st_t;

  typedef struct packed {
    bcpc_port_st_t st;
    logic [1:0]    tries;
    logic [13:0]   ms_left;
    logic          pwr;
  } bcpc_port_t;

  typedef struct packed {
    bcpc_det_st_t  st;
    logic [11:0]   settle;
    logic [16:0]   tick_cnt;
    logic          tick;
    logic [2:0]    code;
    logic          ready;
    logic [7:0]    pce;
    logic [PORTS-1:0] role;
    logic          init_seen;
    bcpc_sense_t   sns_s1;
    bcpc_sense_t   sns_s2;
    logic [PORTS-1:0] oc_s1;
    logic [PORTS-1:0] oc_s2;
  } bcpc_top_t;

endpackage

/* bcpc_port.sv */
// One downstream port: power output and over-current retry timing.
// Assumes a synchronised over-current level and a one-cycle millisecond tick.
`timescale 1ns/10ps
module bcpc_port
  import bcpc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic ms_tick,
  input  wire logic init_done,
  input  wire logic charging,
  input  wire logic dcp_mode,
  input  wire logic oc,
  input  wire logic host_pwr,
  output logic      pwr
);
  bcpc_port_t q, d;

  always_comb begin
    d = q;
    if (!charging) begin
      // Standard port: host owns power and fault handling
      d.st    = PS_OFF;
      d.tries = 2'h0;
      d.pwr   = init_done & host_pwr & ~oc;
    end else begin
      case (q.st)
        PS_OFF: begin
          d.pwr = 1'b0;
          if (init_done) begin
            d.st      = PS_ON;
            d.pwr     = 1'b1;
            d.ms_left = RETRY_SHORT_MS;
          end
        end
        PS_ON: begin
          if (!dcp_mode) begin
            d.pwr = host_pwr & ~oc;
          end else if (oc) begin
            d.pwr     = 1'b0;
            d.st      = PS_BACKOFF;
            d.ms_left = (q.tries == RETRY_SHORT_MAX) ? RETRY_LONG_MS
                                                      : RETRY_SHORT_MS;
            if (q.tries != RETRY_SHORT_MAX) begin
              d.tries = q.tries + 2'h1;
            end
          end else begin
            d.pwr = 1'b1;
            // A full healthy interval forgives earlier faults
            if (ms_tick && q.ms_left != 14'h0) begin
              d.ms_left = q.ms_left - 14'h1;
            end
            if (q.ms_left == 14'h0) begin
              d.tries = 2'h0;
            end
          end
        end
        PS_BACKOFF: begin
          d.pwr = 1'b0;
          if (q.ms_left == 14'h0) begin
            d.st      = PS_ON;
            d.pwr     = 1'b1;
            d.ms_left = RETRY_SHORT_MS;
          end else if (ms_tick) begin
            d.ms_left = q.ms_left - 14'h1;
          end
        end
        default: begin
          d.st  = PS_OFF;
          d.pwr = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{st: PS_OFF, tries: 2'h0, ms_left: 14'h0, pwr: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pwr = q.pwr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_BACKOFF_OFF: assert property (q.st == PS_BACKOFF |-> !pwr)
    else $error("Port powered during back-off");
  AST_LONG_AFTER_THREE: assert property (
    q.st == PS_ON && dcp_mode && charging && oc && q.tries == RETRY_SHORT_MAX
    |=> q.ms_left == RETRY_LONG_MS)
    else $error("Fourth retry did not use the long interval");
  AST_SHORT_FIRST: assert property (
    q.st == PS_ON && dcp_mode && charging && oc && q.tries == 2'h0
    |=> q.ms_left == RETRY_SHORT_MS && q.tries == 2'h1)
    else $error("First retry did not use the short interval");
endmodule

/* bcpc_top.sv */
// Battery charge port control: upstream charger detection and downstream port power.
// Assumes charger sense comparators and over-current pins are asynchronous,
// hub stage signals come from logic on ref_clk, and register writes arrive
// from the serial configuration port as a one-cycle strobe with data.
`timescale 1ns/10ps

module bcpc_top
  import bcpc_pkg::*;
#(
  parameter int TICK_CYCLES = bcpc_pkg::TICK_CYC
)(
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         detect_enable,
  input  wire logic                         enhanced_detect_enable,
  input  wire logic                         osc_detect_enable,
  input  wire logic                         hsic_upstream,
  input  wire logic                         charger_detect_stage,
  input  wire logic                         wait_reference_clock_in_stage,
  input  wire bcpc_pkg::bcpc_sense_t        charger_sense,
  output logic [2:0]                        charger_type_code,
  output logic                              charger_ready_irq,
  input  wire logic                         irq_ack,
  input  wire logic                         pce_wr,
  input  wire logic [bcpc_pkg::PCE_W-1:0]   pce_wdata,
  output logic [bcpc_pkg::PCE_W-1:0]        port_charge_enable,
  input  wire logic                         init_done,
  input  wire logic                         ganged,
  input  wire logic                         host_connected,
  input  wire logic [bcpc_pkg::PORTS-1:0]   ds_hsic,
  input  wire logic [bcpc_pkg::PORTS-1:0]   host_port_power,
  input  wire logic [bcpc_pkg::PORTS-1:0]   overcurrent_sense,
  output logic [bcpc_pkg::PORTS-1:0]        port_role_charging,
  output logic [bcpc_pkg::PORTS-1:0]        port_power_out
);
  import bcpc_pkg::*;

  // ****************************************************************
  // Classification
  // ****************************************************************
  function automatic logic [2:0] classify(input bcpc_sense_t s, input logic enh);
    logic [2:0] c;
    c = CT_NONE;
    if (s.shorted) begin
      c = CT_DCP;
    end else if (s.reflect && enh) begin
      c = CT_CDP;
    end else if (s.prop == PROP_LO) begin
      c = CT_PLO;
    end else if (s.prop == PROP_HI) begin
      c = CT_PHI;
    end else if (s.prop == PROP_SH) begin
      c = CT_PSH;
    end else if (s.pulldowns) begin
      c = CT_SDP;
    end
    return c;
  endfunction

  localparam logic [16:0] TICK_LAST   = 17'(TICK_CYCLES - 1);
  localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYC - 1);

  bcpc_top_t q, d;
  logic      det_go;
  logic      any_oc;
  logic [PORTS-1:0] oc_eff;
  logic      det_end;
  logic [PORTS-1:0] ds_hsic_cap;

  // Detection may run on the internal oscillator while reference_clock_in is awaited
  assign det_go = detect_enable && !hsic_upstream &&
                  (charger_detect_stage || (wait_reference_clock_in_stage && osc_detect_enable));
  assign any_oc = |q.oc_s2;
  assign oc_eff = ganged ? {PORTS{any_oc}} : q.oc_s2;
  assign det_end = (q.st == DS_SETTLE) && (q.settle == SETTLE_LAST) && det_go;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.sns_s1 = charger_sense;
    d.sns_s2 = q.sns_s1;
    d.oc_s1  = overcurrent_sense;
    d.oc_s2  = q.oc_s1;

    d.tick = 1'b0;
    if (q.tick_cnt == TICK_LAST) begin
      d.tick_cnt = 17'h0;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 17'h1;
    end

    // Custom detection by software has no interlock here; it relies on stage discipline
    if (pce_wr) begin
      d.pce = pce_wdata & ~PCE_RSVD_MSK;
    end

    // Role captured once at end of initialization and never revisited
    if (init_done && !q.init_seen) begin
      d.init_seen = 1'b1;
      d.role      = q.pce[PCE_PORT1 +: PORTS] & ~ds_hsic;
    end

    // Acknowledge clears the flag unless a new result lands the same cycle
    if (irq_ack) begin
      d.ready = 1'b0;
    end

    case (q.st)
      DS_IDLE: begin
        if (det_go) begin
          d.st     = DS_SETTLE;
          d.settle = 12'h0;
        end
      end
      DS_SETTLE: begin
        if (!det_go) begin
          d.st = DS_IDLE;
        end else if (q.settle == SETTLE_LAST) begin
          d.st    = DS_DONE;
          d.code  = classify(q.sns_s2, enhanced_detect_enable);
          d.ready = 1'b1;
        end else begin
          d.settle = q.settle + 12'h1;
        end
      end
      DS_DONE: begin
        if (!det_go) begin
          d.st = DS_IDLE;
        end
      end
      default: begin
        d.st = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{st: DS_IDLE, settle: 12'h0, tick_cnt: 17'h0, tick: 1'b0, code: CT_NONE,
             ready: 1'b0, pce: PCE_RST, role: '0, init_seen: 1'b0,
             sns_s1: '0, sns_s2: '0, oc_s1: '0, oc_s2: '0};
    end else begin
      q <= d;
    end
  end

  assign charger_type_code  = q.code;
  assign charger_ready_irq  = q.ready;
  assign port_charge_enable = q.pce;
  assign port_role_charging = q.role;

  // ****************************************************************
  // Downstream ports
  // ****************************************************************
  for (genvar i = 0; i < PORTS; i++) begin : g_port
    bcpc_port u_port (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .ms_tick   (q.tick),
      .init_done (q.init_seen),
      .charging  (q.role[i]),
      .dcp_mode  (q.role[i] & ~host_connected),
      .oc        (oc_eff[i]),
      .host_pwr  (host_port_power[i]),
      .pwr       (port_power_out[i])
    );
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_DET_START: assert property (q.st == DS_IDLE && det_go |=> q.st == DS_SETTLE)
    else $error("Detection did not start");
  AST_HSIC_NO_DET: assert property (hsic_upstream && q.st == DS_IDLE |=> q.st == DS_IDLE)
    else $error("Detection ran on HSIC upstream");
  AST_CDP_GATED: assert property (
    q.st == DS_SETTLE && q.settle == SETTLE_LAST && det_go && !enhanced_detect_enable
    |=> charger_type_code != CT_CDP)
    else $error("CDP reported without enhanced detect");
  AST_DCP_CODE: assert property (
    q.st == DS_SETTLE && q.settle == SETTLE_LAST && det_go && q.sns_s2.shorted
    |=> charger_type_code == CT_DCP && charger_ready_irq)
    else $error("Shorted lines not reported as DCP with interrupt");
  AST_PROP_SH: assert property (
    q.st == DS_SETTLE && q.settle == SETTLE_LAST && det_go && !q.sns_s2.shorted &&
    !(q.sns_s2.reflect && enhanced_detect_enable) && q.sns_s2.prop == PROP_SH
    |=> charger_type_code == CT_PSH)
    else $error("Super-high proprietary charger misreported");
  AST_ROLE_FIXED: assert property (q.init_seen |=> $stable(q.role))
    else $error("Port role changed after initialization");
  AST_HSIC_NO_CHG: assert property (q.init_seen |-> (q.role & ds_hsic_cap) == '0)
    else $error("HSIC port given a charging role");
  AST_CHG_PWR_UP: assert property (
    $rose(q.init_seen) && ganged == 1'b0 && oc_eff == '0
    |=> ##1 (port_power_out & q.role) == q.role)
    else $error("Charging port not powered after initialization");
  AST_OC_DROP: assert property (
    q.init_seen && any_oc && ganged |=> port_power_out == '0)
    else $error("Ganged over-current left a port powered");
  AST_NONE_AFTER_RST: assert property ($fell(sys_rst) |-> charger_type_code == CT_NONE)
    else $error("Charger type not cleared by reset");

  // ****************************************************************
  // Register, flag and classifier checks
  // ****************************************************************
  AST_PCE_WRITE: assert property (
    pce_wr
    |=> port_charge_enable == ($past(pce_wdata) & ~PCE_RSVD_MSK))
    else $error("Enable register write not taken");

  AST_PCE_HOLD: assert property (
    !pce_wr
    |=> $stable(port_charge_enable))
    else $error("Enable register changed without a write");

  AST_IRQ_HOLD: assert property (
    charger_ready_irq && !irq_ack
    |=> charger_ready_irq)
    else $error("Ready flag dropped without acknowledge");

  AST_IRQ_CLEAR: assert property (
    irq_ack && !det_end
    |=> !charger_ready_irq)
    else $error("Ready flag not cleared by acknowledge");

  AST_IRQ_SET_WINS: assert property (
    det_end
    |=> charger_ready_irq)
    else $error("New result did not raise the ready flag");

  AST_CODE_HOLD: assert property (
    !det_end
    |=> $stable(charger_type_code))
    else $error("Charger type changed without a result");

  AST_ABORT: assert property (
    q.st == DS_SETTLE && !det_go
    |=> q.st == DS_IDLE)
    else $error("Detection not aborted when go fell");

  AST_DONE_STAY: assert property (
    q.st == DS_DONE && det_go
    |=> q.st == DS_DONE)
    else $error("Detection restarted while go stayed high");

  AST_IDLE_STAY: assert property (
    q.st == DS_IDLE && !det_go
    |=> q.st == DS_IDLE)
    else $error("Detection started without go");

  AST_SETTLE_COUNT: assert property (
    q.st == DS_SETTLE && det_go && q.settle != SETTLE_LAST
    |=> q.settle == $past(q.settle) + 12'h1)
    else $error("Settle counter did not advance");

  AST_CDP_CODE: assert property (
    det_end && !q.sns_s2.shorted && q.sns_s2.reflect && enhanced_detect_enable
    |=> charger_type_code == CT_CDP)
    else $error("Reflected line not reported as CDP");

  AST_SDP_CODE: assert property (
    det_end && !q.sns_s2.shorted && !q.sns_s2.reflect && q.sns_s2.prop == PROP_NONE &&
    q.sns_s2.pulldowns
    |=> charger_type_code == CT_SDP)
    else $error("Pull-downs not reported as SDP");

  AST_PLO_CODE: assert property (
    det_end && !q.sns_s2.shorted && !q.sns_s2.reflect && q.sns_s2.prop == PROP_LO
    |=> charger_type_code == CT_PLO)
    else $error("Low current charger misreported");

  AST_PHI_CODE: assert property (
    det_end && !q.sns_s2.shorted && !q.sns_s2.reflect && q.sns_s2.prop == PROP_HI
    |=> charger_type_code == CT_PHI)
    else $error("High current charger misreported");

  AST_NONE_CODE: assert property (
    det_end && q.sns_s2 == '0
    |=> charger_type_code == CT_NONE)
    else $error("Empty line reported as a charger");

  AST_TICK_RANGE: assert property (
    q.tick_cnt <= TICK_LAST)
    else $error("Tick counter out of range");

  AST_INIT_STICKY: assert property (
    q.init_seen
    |=> q.init_seen)
    else $error("Initialization flag dropped");

  AST_PRE_INIT_OFF: assert property (
    !q.init_seen
    |-> port_power_out == '0)
    else $error("Port powered before initialization");

  // ****************************************************************
  // Per-port checks
  // ****************************************************************
  for (genvar i = 0; i < PORTS; i++) begin : g_chk
    AST_SDP_FOLLOW: assert property (
      q.init_seen && !q.role[i]
      |=> port_power_out[i] == $past(host_port_power[i] & ~oc_eff[i]))
      else $error("Standard port did not follow host power");

    AST_IND_OC: assert property (
      !ganged && oc_eff[i] && !q.role[i]
      |=> !port_power_out[i])
      else $error("Over-current left a standard port powered");
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ds_hsic_cap <= '0;
    end else if (init_done && !q.init_seen) begin
      ds_hsic_cap <= ds_hsic;
    end
  end

  COV_DCP_FOUND: cover property (q.st == DS_SETTLE ##1 charger_type_code == CT_DCP);
  COV_IRQ_ACK:   cover property (charger_ready_irq ##1 irq_ack ##1 !charger_ready_irq);
  COV_BACKOFF:   cover property (q.role[0] && !host_connected && oc_eff[0] ##1 !port_power_out[0]);
  COV_CDP_FOUND: cover property (det_end && enhanced_detect_enable && q.sns_s2.reflect);
  COV_GANGED_OC: cover property (ganged && any_oc ##1 port_power_out == '0);
endmodule

/* bcpc_partner.sv */
// Far side model: upstream charger profile and downstream port loads.
// Assumes the bench picks the profile and the faulty loads; outputs are registered on ref_clk.
`timescale 1ns/10ps
module bcpc_partner
(
  input  wire logic                        ref_clk,
  input  wire logic [2:0]                  profile,
  input  wire logic [bcpc_pkg::PORTS-1:0]  short_load,
  input  wire logic [bcpc_pkg::PORTS-1:0]  port_power_out,
  output bcpc_pkg::bcpc_sense_t            charger_sense,
  output logic [bcpc_pkg::PORTS-1:0]       overcurrent_sense
);
  import bcpc_pkg::*;
  // ****************************************************************
  // Loads and line profiles
  // ****************************************************************
  // A faulty load only draws excess current while it is powered
  always_ff @(posedge ref_clk) begin
    overcurrent_sense <= short_load & port_power_out;
    case (profile)
      3'h1: charger_sense <= '{1'b1, 1'b0, 1'b0, PROP_NONE};
      // A charging host also shows its pull-downs, so weak decoders fall to 011
      3'h2: charger_sense <= '{1'b0, 1'b1, 1'b1, PROP_NONE};
      3'h3: charger_sense <= '{1'b0, 1'b1, 1'b0, PROP_NONE};
      3'h4: charger_sense <= '{1'b0, 1'b0, 1'b0, PROP_LO};
      3'h5: charger_sense <= '{1'b0, 1'b0, 1'b0, PROP_HI};
      3'h6: charger_sense <= '{1'b0, 1'b0, 1'b0, PROP_SH};
      default: charger_sense <= '0;
    endcase
  end
endmodule

/* test_battery_charge_port_control.sv */
// Self-checking bench for the battery charge port control block.
// Assumes bcpc_pkg is compiled first; the tick is shortened to 2 cycles.
`timescale 1ns/10ps
module test_battery_charge_port_control;
  import bcpc_pkg::*;
  localparam int TK = 2;
  logic             ref_clk, sys_rst, detect_enable, enhanced_detect_enable;
  logic             osc_detect_enable, hsic_upstream, charger_detect_stage;
  logic             wait_reference_clock_in_stage, charger_ready_irq, irq_ack, pce_wr;
  logic             init_done, ganged, host_connected;
  logic [2:0]       charger_type_code, profile;
  logic [7:0]       pce_wdata, port_charge_enable;
  logic [PORTS-1:0] ds_hsic, host_port_power, overcurrent_sense;
  logic [PORTS-1:0] port_role_charging, port_power_out, short_load;
  bcpc_sense_t      charger_sense;
  int               err_total, checks, n, lim;

  // ****************************************************************
  // Instances
  // ****************************************************************
  bcpc_top #(.TICK_CYCLES(TK)) uut (.ref_clk, .sys_rst, .detect_enable,
    .enhanced_detect_enable, .osc_detect_enable, .hsic_upstream, .charger_detect_stage,
    .wait_reference_clock_in_stage, .charger_sense, .charger_type_code, .charger_ready_irq, .irq_ack,
    .pce_wr, .pce_wdata, .port_charge_enable, .init_done, .ganged, .host_connected,
    .ds_hsic, .host_port_power, .overcurrent_sense, .port_role_charging, .port_power_out);
  bcpc_partner far (.ref_clk, .profile, .short_load, .port_power_out, .charger_sense,
    .overcurrent_sense);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wait_irq(output int c);
    c = 0;
    while (charger_ready_irq !== 1'b1 && c < 4100) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic wait_pwr(input int i, input logic v, input int lm, output int c);
    c = 0;
    while (port_power_out[i] !== v && c < lm) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic pce_write(input logic [7:0] d);
    pce_wr = 1'b1;
    pce_wdata = d;
    cyc(1);
    pce_wr = 1'b0;
    cyc(1);
  endtask
  // Range checks pass the expected figure through, so a miss prints what was seen
  // Only the automatic sequence is exercised; no custom detection is driven
  task automatic detect(input logic [2:0] p, input logic en, input logic [2:0] exp);
    profile = p;
    enhanced_detect_enable = en;
    cyc(4);
    charger_detect_stage = 1'b1;
    wait_irq(n);
    chk("detect cycles", 4001, (n > 3995 && n < 4008) ? 4001 : n);
    chk("type code", exp, charger_type_code);
    charger_detect_stage = 1'b0;
    irq_ack = 1'b1;
    cyc(1);
    irq_ack = 1'b0;
    cyc(1);
    chk("irq after ack", 0, charger_ready_irq);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk("code at reset", CT_NONE, charger_type_code);
    chk("irq at reset", 0, charger_ready_irq);
    chk("enable at reset", PCE_RST, port_charge_enable);
    $display("reset test done");
  endtask
  task automatic t_detect();
    detect_enable = 1'b1;
    detect(3'h1, 1'b0, CT_DCP);
    detect(3'h3, 1'b0, CT_SDP);
    detect(3'h2, 1'b1, CT_CDP);
    detect(3'h2, 1'b0, CT_SDP);
    detect(3'h4, 1'b0, CT_PLO);
    detect(3'h5, 1'b0, CT_PHI);
    detect(3'h6, 1'b0, CT_PSH);
    $display("detect test done");
  endtask
  task automatic t_block();
    profile = 3'h1;
    for (int k = 0; k < 3; k++) begin
      detect_enable = (k != 0);
      hsic_upstream = (k == 1);
      charger_detect_stage = (k != 2);
      wait_reference_clock_in_stage = (k == 2);
      cyc(4100);
      chk("irq while blocked", 0, charger_ready_irq);
      charger_detect_stage = 1'b0;
      cyc(2);
    end
    osc_detect_enable = 1'b1;
    wait_irq(n);
    chk("osc detect code", CT_DCP, charger_type_code);
    wait_reference_clock_in_stage = 1'b0;
    osc_detect_enable = 1'b0;
    $display("blocking test done");
  endtask
  task automatic t_ports();
    pce_write(8'h0f);
    chk("enable readback", 8'h0e, port_charge_enable);
    chk("power before init", 0, port_power_out);
    init_done = 1'b1;
    cyc(4);
    chk("role", 4'b0011, port_role_charging);
    chk("power after init", 4'b0011, port_power_out);
    pce_write(8'h00);
    cyc(3);
    chk("role after write", 4'b0011, port_role_charging);
    host_port_power = 4'b1100;
    cyc(4);
    chk("standard ports", 4'b1111, port_power_out);
    host_connected = 1'b1;
    host_port_power = 4'b0001;
    cyc(4);
    chk("host present", 4'b0001, port_power_out);
    host_connected = 1'b0;
    host_port_power = 4'b0000;
    cyc(4);
    $display("port test done");
  endtask
  task automatic t_fault();
    ganged = 1'b1;
    short_load = 4'b0010;
    wait_pwr(0, 1'b0, 30, n);
    chk("ganged power", 0, port_power_out);
    short_load = 4'b0000;
    wait_pwr(0, 1'b1, 2100, n);
    lim = RETRY_SHORT_MS * TK;
    chk("ganged off cycles", lim, (n > lim - 8 && n < lim + 2) ? lim : n);
    ganged = 1'b0;
    cyc(2200);
    short_load = 4'b0001;
    for (int k = 0; k < 4; k++) begin
      lim = (k < RETRY_SHORT_MAX) ? RETRY_SHORT_MS * TK : RETRY_LONG_MS * TK;
      wait_pwr(0, 1'b0, 30, n);
      chk("neighbour power", 1, port_power_out[1]);
      wait_pwr(0, 1'b1, 20100, n);
      chk("off cycles", lim, (n > lim - 6 && n < lim + 6) ? lim : n);
    end
    short_load = 4'b0000;
    $display("fault test done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    {detect_enable, enhanced_detect_enable, osc_detect_enable, hsic_upstream} = '0;
    {charger_detect_stage, wait_reference_clock_in_stage, irq_ack, pce_wr} = '0;
    {init_done, ganged, host_connected} = '0;
    {pce_wdata, ds_hsic, host_port_power, short_load, profile} = '0;
    ds_hsic = 4'b0100;
    err_total = 0;
    checks = 0;
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    cyc(1);
    t_reset();
    t_detect();
    t_block();
    t_ports();
    t_fault();
    complete_run();
  end
  // The full run needs about 75000 cycles
  initial begin
    repeat (96000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end
endmodule
